// *** arsp_port.sv ***
// Output side of the converter: sampling, formatting and serial result port.
`timescale 1ns/1ns
`default_nettype none
`include "arsp_defs.svh"

module arsp_port
   import arsp_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     conv_clk,
   input  wire logic [`ARSP_RES_W-1:0]   sample_code,
   input  wire logic                     below_bottom_ref,
   input  wire logic                     above_top_ref,
   input  wire logic                     msb_invert_sel,
   input  wire logic                     lsb_invert_sel,
   input  wire logic                     load_strobe_n,
   input  wire logic                     shift_clk,
   input  wire logic                     freeze_results,
   output var  logic                     serial_result_out,
   output var  logic                     underrange_flag,
   output var  logic                     overrange_flag,
   output var  logic                     sample_phase,
   output var  logic                     sample_overrun
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                    conv_q;
      logic                    sclk_q;
      arsp_word_t              stage1;
      arsp_word_t              stage2;
      arsp_word_t              latch;
      logic [`ARSP_RES_W-1:0]  shreg;
      logic                    phase;
      logic                    overrun;
   } arsp_port_st_t;

   arsp_port_st_t st_ff;
   arsp_port_st_t nxt_st;

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [`ARSP_PIN_W-1:0] pins;
   logic                   conv_s;
   logic                   sclk_s;
   logic                   load_n_s;
   logic                   msb_invert_sel_s;
   logic                   lsb_invert_sel_s;
   logic                   freeze_s;

   // The invert stages reset low so a floating select reads as straight binary.
   arsp_sync #(
      .W       (`ARSP_PIN_W),
      .RST_VAL (`ARSP_PIN_RST)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pin_in   ({freeze_results, lsb_invert_sel, msb_invert_sel,
                  load_strobe_n, shift_clk, conv_clk}),
      .pin_sync (pins)
   );

   assign conv_s   = pins[`ARSP_PIN_CONV];
   assign sclk_s   = pins[`ARSP_PIN_SCLK];
   assign load_n_s = pins[`ARSP_PIN_LOAD_N];
   assign msb_invert_sel_s   = pins[`ARSP_PIN_MSB_INVERT_SEL];
   assign lsb_invert_sel_s   = pins[`ARSP_PIN_LSB_INVERT_SEL];
   assign freeze_s = pins[`ARSP_PIN_FREEZE];

   // -------------------------------------------------------------------------
   // Edge events
   // -------------------------------------------------------------------------
   logic conv_fall;
   logic conv_rise;
   logic sclk_rise;
   logic advance;

   assign conv_fall = st_ff.conv_q && !conv_s;
   assign conv_rise = !st_ff.conv_q && conv_s;
   assign sclk_rise = !st_ff.sclk_q && sclk_s;
   // Freezing stalls the whole output pipe, so the FIFO takes up the slack.
   assign advance   = conv_rise && !freeze_s;

   // -------------------------------------------------------------------------
   // Sample capture and result FIFO
   // -------------------------------------------------------------------------
   arsp_word_if #(.W(`ARSP_WORD_W)) smp_if ();
   arsp_word_if #(.W(`ARSP_WORD_W)) pipe_if ();
   arsp_word_t  smp_word;
   arsp_word_t  head_word;

   // Underrange wins if the comparators ever report both at once.
   always_comb begin
      smp_word      = '0;
      smp_word.und  = below_bottom_ref;
      smp_word.ovr  = above_top_ref && !below_bottom_ref;
      if (below_bottom_ref) begin
         smp_word.code = `ARSP_CODE_ZERO;
      end else if (above_top_ref) begin
         smp_word.code = `ARSP_CODE_FULL;
      end else begin
         smp_word.code = sample_code;
      end
   end

   assign smp_if.valid  = conv_fall;
   assign smp_if.data   = smp_word;
   assign pipe_if.ready = advance;
   assign head_word     = pipe_if.data;

   arsp_fifo #(
      .W     (`ARSP_WORD_W),
      .DEPTH (`ARSP_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wr      (smp_if),
      .rd      (pipe_if)
   );

   // -------------------------------------------------------------------------
   // Output formatting
   // -------------------------------------------------------------------------
   arsp_word_t fmt_word;

   always_comb begin
      fmt_word      = st_ff.stage2;
      fmt_word.code = st_ff.stage2.code
                      ^ (msb_invert_sel_s ? `ARSP_MSB_MASK : `ARSP_CODE_ZERO)
                      ^ (lsb_invert_sel_s ? `ARSP_LSB_MASK : `ARSP_CODE_ZERO);
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.conv_q  = conv_s;
      nxt_st.sclk_q  = sclk_s;
      nxt_st.phase   = conv_s;
      nxt_st.overrun = conv_fall && !smp_if.ready;
      // Half a cycle in the FIFO plus two rising edges gives 2.5 cycles.
      if (advance) begin
         if (pipe_if.valid) begin
            nxt_st.stage1 = head_word;
         end
         nxt_st.stage2 = st_ff.stage1;
         // Inverts are applied only here, at the output latch.
         nxt_st.latch  = fmt_word;
      end
      if (!load_n_s) begin
         nxt_st.shreg = st_ff.latch.code;
      end else if (sclk_rise) begin
         nxt_st.shreg = {st_ff.shreg[`ARSP_MSB-1:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff          <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign serial_result_out = st_ff.shreg[`ARSP_MSB];
   assign underrange_flag   = st_ff.latch.und;
   assign overrange_flag    = st_ff.latch.ovr;
   assign sample_phase      = st_ff.phase;
   assign sample_overrun    = st_ff.overrun;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_under_code;
      advance && st_ff.stage2.und |=> underrange_flag && !overrange_flag &&
         (st_ff.latch.code ^ {$past(msb_invert_sel_s), {11{$past(lsb_invert_sel_s)}}}) == `ARSP_CODE_ZERO;
   endproperty
   a_under_code: assert property (p_under_code)
      else $error("underrange result is not negative full scale");

   property p_over_code;
      advance && st_ff.stage2.ovr |=> overrange_flag && !underrange_flag &&
         (st_ff.latch.code ^ {$past(msb_invert_sel_s), {11{$past(lsb_invert_sel_s)}}}) == `ARSP_CODE_FULL;
   endproperty
   a_over_code: assert property (p_over_code)
      else $error("overrange result is not positive full scale");

   property p_load_msb;
      !load_n_s [*2] |-> serial_result_out == $past(st_ff.latch.code[11]);
   endproperty
   a_load_msb: assert property (p_load_msb)
      else $error("serial output does not show the loaded msb");

   property p_shift_step;
      load_n_s && sclk_rise |=> st_ff.shreg == {$past(st_ff.shreg[10:0]), 1'b0};
   endproperty
   a_shift_step: assert property (p_shift_step)
      else $error("shift clock rise did not advance the serial output");

   property p_no_fall_shift;
      load_n_s && !sclk_rise |=> $stable(st_ff.shreg);
   endproperty
   a_no_fall_shift: assert property (p_no_fall_shift)
      else $error("serial register moved without a shift clock rise");

   property p_load_wins;
      !load_n_s && sclk_rise |=> st_ff.shreg == $past(st_ff.latch.code);
   endproperty
   a_load_wins: assert property (p_load_wins)
      else $error("shift clock moved the register during load");

   property p_load_level;
      !load_n_s ##1 !load_n_s |=> st_ff.shreg == $past(st_ff.latch.code);
   endproperty
   a_load_level: assert property (p_load_level)
      else $error("register stopped tracking the result while loading");

   property p_phase;
      conv_fall |=> !sample_phase;
   endproperty
   a_phase: assert property (p_phase)
      else $error("sample phase did not fall with the conversion clock");

   property p_capture;
      conv_fall && smp_if.ready && !freeze_s |=> pipe_if.valid;
   endproperty
   a_capture: assert property (p_capture)
      else $error("falling conversion clock did not capture a sample");

   property p_msb_inv;
      advance |=> st_ff.latch.code[11] == ($past(st_ff.stage2.code[11]) ^ $past(msb_invert_sel_s));
   endproperty
   a_msb_inv: assert property (p_msb_inv)
      else $error("msb format wrong");

   property p_lsb_inv;
      advance |=> st_ff.latch.code[10:0]
                  == ($past(st_ff.stage2.code[10:0]) ^ {11{$past(lsb_invert_sel_s)}});
   endproperty
   a_lsb_inv: assert property (p_lsb_inv)
      else $error("lsb format wrong");

   property p_flags_fixed;
      advance |=> {overrange_flag, underrange_flag}
                  == $past({st_ff.stage2.ovr, st_ff.stage2.und});
   endproperty
   a_flags_fixed: assert property (p_flags_fixed)
      else $error("range flags altered by formatting");

   property p_latch_hold;
      !advance |=> $stable(st_ff.latch);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("output latch changed between conversion clock rises");

   property p_zero_fill;
      load_n_s && sclk_rise |=> st_ff.shreg[0] == 1'b0;
   endproperty
   a_zero_fill: assert property (p_zero_fill)
      else $error("shift did not bring in a zero");

   property p_phase_high;
      conv_rise |=> sample_phase;
   endproperty
   a_phase_high: assert property (p_phase_high)
      else $error("sample phase did not rise with the conversion clock");

   property p_capture_under;
      smp_if.valid && below_bottom_ref |-> smp_word.und && !smp_word.ovr &&
         smp_word.code == `ARSP_CODE_ZERO;
   endproperty
   a_capture_under: assert property (p_capture_under)
      else $error("underrange sample not forced to zero code");

   property p_capture_over;
      smp_if.valid && above_top_ref && !below_bottom_ref |-> smp_word.ovr &&
         smp_word.code == `ARSP_CODE_FULL;
   endproperty
   a_capture_over: assert property (p_capture_over)
      else $error("overrange sample not forced to full code");

   property p_flags_excl;
      !(underrange_flag && overrange_flag);
   endproperty
   a_flags_excl: assert property (p_flags_excl)
      else $error("both range flags high at once");

   property p_pipe_step;
      advance |=> st_ff.stage2 == $past(st_ff.stage1);
   endproperty
   a_pipe_step: assert property (p_pipe_step)
      else $error("pipeline stage did not advance");

   property p_head_take;
      advance && pipe_if.valid |=> st_ff.stage1 == $past(head_word);
   endproperty
   a_head_take: assert property (p_head_take)
      else $error("first stage did not take the buffered sample");

   property p_overrun;
      conv_fall && !smp_if.ready |=> sample_overrun;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("dropped sample not reported");

   property p_shift_out;
      load_n_s && sclk_rise |=> serial_result_out == $past(st_ff.shreg[10]);
   endproperty
   a_shift_out: assert property (p_shift_out)
      else $error("serial output did not show the next bit");

endmodule : arsp_port

`default_nettype wire

// *** arsp_defs.svh ***
// Constants for the serial result port of the sampling converter.
`ifndef ARSP_DEFS_SVH
`define ARSP_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------------
`define ARSP_RES_W        12
`define ARSP_MSB          11
`define ARSP_WORD_W       14
`define ARSP_FIFO_DEPTH   8
`define ARSP_PIN_W        6

// ----------------------------------------------------------------------------
// Pin synchroniser bit positions and reset values
// ----------------------------------------------------------------------------
`define ARSP_PIN_CONV     0
`define ARSP_PIN_SCLK     1
`define ARSP_PIN_LOAD_N   2
`define ARSP_PIN_MSB_INVERT_SEL     3
`define ARSP_PIN_LSB_INVERT_SEL     4
`define ARSP_PIN_FREEZE   5
`define ARSP_PIN_RST      6'h04

// ----------------------------------------------------------------------------
// Result codes
// ----------------------------------------------------------------------------
`define ARSP_CODE_ZERO    12'h000
`define ARSP_CODE_FULL    12'hFFF
`define ARSP_LSB_MASK     12'h7FF
`define ARSP_MSB_MASK     12'h800

`endif

// *** arsp_pkg.sv ***
// Types shared by the serial result port modules.
`include "arsp_defs.svh"

package arsp_pkg;

   // -------------------------------------------------------------------------
   // One conversion result with its range flags
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                     ovr;
      logic                     und;
      logic [`ARSP_RES_W-1:0]   code;
   } arsp_word_t;

endpackage : arsp_pkg

// *** arsp_word_if.sv ***
// Valid/ready carrier for result words between the port modules.
`timescale 1ns/1ns
`default_nettype none

interface arsp_word_if #(
   parameter int W = 14
);
   logic           valid;
   logic           ready;
   logic [W-1:0]   data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : arsp_word_if

`default_nettype wire

// *** arsp_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ns
`default_nettype none

module arsp_sync #(
   parameter int           W       = 6,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [W-1:0]  pin_in,
   output var  logic [W-1:0]  pin_sync
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } arsp_sync_st_t;

   arsp_sync_st_t st_ff;
   arsp_sync_st_t nxt_st;

   // The first stage feeds only the second stage.
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.stage1 = pin_in;
      nxt_st.stage2 = st_ff.stage1;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= {RST_VAL, RST_VAL};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_sync = st_ff.stage2;
endmodule : arsp_sync

`default_nettype wire

// *** arsp_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module arsp_fifo #(
   parameter int W     = 14,
   parameter int DEPTH = 8
) (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   arsp_word_if.snk   wr,
   arsp_word_if.src   rd
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } arsp_fifo_st_t;

   arsp_fifo_st_t st_ff;
   arsp_fifo_st_t nxt_st;
   logic          push;
   logic          pop;

   assign wr.ready = (st_ff.cnt != (AW+1)'(DEPTH));
   assign rd.valid = (st_ff.cnt != '0);
   assign rd.data  = st_ff.mem[st_ff.rp];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wp] = wr.data;
         nxt_st.wp            = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
      end
      case ({push, pop})
         2'b10:   nxt_st.cnt = st_ff.cnt + 1'b1;
         2'b01:   nxt_st.cnt = st_ff.cnt - 1'b1;
         default: nxt_st.cnt = st_ff.cnt;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : arsp_fifo

`default_nettype wire

// *** arsp_host_model.sv ***
// Host controller model that loads and shifts out conversion results.
`timescale 1ns/1ns
`default_nettype none

module arsp_host_model (
   input  wire logic         ref_clk,
   input  wire logic         read_req,
   input  wire logic         extra_shift,
   input  wire logic         hold_load,
   input  wire logic         serial_result_out,
   output var  logic         load_strobe_n,
   output var  logic         shift_clk,
   output var  logic [11:0]  read_word,
   output var  logic         tail_bit,
   output var  logic         read_done
);
   // ------------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------------
   // The shift clock runs only inside a frame or while a load is held, so it sits low between them.
   // Bits are taken just before each rise, long after the previous shift settled.
   initial begin
      load_strobe_n = 1'b1;
      shift_clk     = 1'b0;
      read_word     = '0;
      tail_bit      = 1'b0;
      read_done     = 1'b0;
      forever begin
         @(posedge ref_clk iff (read_req || hold_load));
         #3;
         if (hold_load) begin
            load_strobe_n = 1'b0;
            while (hold_load) begin
               #62 shift_clk = 1'b1;
               #63 shift_clk = 1'b0;
            end
            load_strobe_n = 1'b1;
         end else begin
            load_strobe_n = 1'b0;
            #60 load_strobe_n = 1'b1;
            #62;
            for (int i = 0; i < 13; i++) begin
               if (i < 12 || extra_shift) begin
                  if (i < 12)
                     read_word[11-i] = serial_result_out;
                  else
                     tail_bit = serial_result_out;
                  shift_clk = 1'b1;
                  #62 shift_clk = 1'b0;
                  #63;
               end
            end
            read_done = 1'b1;
            wait (!read_req);
            read_done = 1'b0;
         end
      end
   end
endmodule : arsp_host_model

`default_nettype wire

// *** arsp_port_test.sv ***
// Self-checking testbench for the serial result port.
`timescale 1ns/1ns
`default_nettype none
`include "arsp_defs.svh"

`define TB_CHK(name, got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", name, exp, got); end end

module arsp_port_test;
   logic         ref_clk, rst, conv_clk, below_bottom_ref, above_top_ref;
   logic         msb_invert_sel, lsb_invert_sel, freeze_results;
   logic [11:0]  sample_code, read_word, exp_w;
   logic         load_strobe_n, shift_clk, serial_result_out, underrange_flag;
   logic         overrange_flag, sample_phase, sample_overrun;
   logic         read_req, extra_shift, hold_load, tail_bit, read_done;
   int           fails, check_count, ovr_count;

   arsp_port DUT (.ref_clk(ref_clk), .rst(rst), .conv_clk(conv_clk),
      .sample_code(sample_code), .below_bottom_ref(below_bottom_ref),
      .above_top_ref(above_top_ref), .msb_invert_sel(msb_invert_sel),
      .lsb_invert_sel(lsb_invert_sel), .load_strobe_n(load_strobe_n),
      .shift_clk(shift_clk), .freeze_results(freeze_results),
      .serial_result_out(serial_result_out), .underrange_flag(underrange_flag),
      .overrange_flag(overrange_flag), .sample_phase(sample_phase),
      .sample_overrun(sample_overrun));

   arsp_host_model host (.ref_clk(ref_clk), .read_req(read_req), .extra_shift(extra_shift),
      .hold_load(hold_load), .serial_result_out(serial_result_out),
      .load_strobe_n(load_strobe_n), .shift_clk(shift_clk), .read_word(read_word),
      .tail_bit(tail_bit), .read_done(read_done));

   // ------------------------------------------------------------------
   // Clock, overrun counter and watchdog
   // ------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Counting on the falling edge keeps the pulse away from its launching edge.
   always @(negedge ref_clk) begin
      if (sample_overrun === 1'b1) ovr_count++;
   end

   // The tests need about 6000 cycles; ten times that means a hang.
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      $display("Watchdog expired");
      finish_test();
   end

   // ------------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------------
   // One conversion period; inverts change only while the conversion clock is low.
   task automatic conv(input logic [11:0] code, input logic b, input logic a,
                       input logic mi, input logic li);
      @(posedge ref_clk);
      conv_clk         <= 1'b0;
      sample_code      <= code;
      below_bottom_ref <= b;
      above_top_ref    <= a;
      msb_invert_sel   <= mi;
      lsb_invert_sel   <= li;
      repeat (20) @(posedge ref_clk);
      `TB_CHK("phase low", sample_phase, 1'b0);
      conv_clk <= 1'b1;
      repeat (20) @(posedge ref_clk);
      `TB_CHK("phase high", sample_phase, 1'b1);
   endtask : conv

   task automatic read_check(input logic [11:0] code, input logic u, input logic o);
      int n;
      n = 0;
      read_req <= 1'b1;
      while (read_done !== 1'b1 && n < 1000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 1000) fails++;
      read_req <= 1'b0;
      @(posedge ref_clk);
      `TB_CHK("word", read_word, code);
      `TB_CHK("under", underrange_flag, u);
      `TB_CHK("over", overrange_flag, o);
   endtask : read_check

   // Sample, let two more periods carry it to the output latch, then read it.
   task automatic stream_check(input logic [11:0] code, input logic b, input logic a,
                               input logic mi, input logic li);
      logic [11:0] base;
      base = b ? `ARSP_CODE_ZERO : (a ? `ARSP_CODE_FULL : code);
      base = base ^ (mi ? `ARSP_MSB_MASK : 12'h000) ^ (li ? `ARSP_LSB_MASK : 12'h000);
      conv(code, b, a, mi, li);
      conv(12'h000, 1'b0, 1'b0, mi, li);
      conv(12'h000, 1'b0, 1'b0, mi, li);
      read_check(base, b, a & ~b);
   endtask : stream_check

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      conv_clk = 1'b1;
      sample_code = 12'h000;
      below_bottom_ref = 1'b0;
      above_top_ref = 1'b0;
      msb_invert_sel = 1'b0;
      lsb_invert_sel = 1'b0;
      freeze_results = 1'b0;
      read_req = 1'b0;
      extra_shift = 1'b0;
      hold_load = 1'b0;
      fails = 0;
      check_count = 0;
      ovr_count = 0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      for (int f = 0; f < 4; f++) begin
         stream_check(12'hA5C, 1'b0, 1'b0, f[1], f[0]);
      end
      stream_check(12'hFFF, 1'b0, 1'b0, 1'b0, 1'b0);
      conv(12'h000, 1'b0, 1'b0, 1'b0, 1'b0);
      read_check(12'h000, 1'b0, 1'b0);
      $display("Test format done");
      stream_check(12'h123, 1'b1, 1'b0, 1'b1, 1'b0);
      stream_check(12'h456, 1'b0, 1'b1, 1'b0, 1'b1);
      stream_check(12'h789, 1'b1, 1'b0, 1'b1, 1'b1);
      $display("Test range done");
      // Watching the sample phase and stretching the clock shifts its phase.
      @(posedge ref_clk iff sample_phase === 1'b1);
      repeat (7) @(posedge ref_clk);
      // Inverts change half a period before the latch takes the sample.
      conv(12'h111, 1'b0, 1'b0, 1'b0, 1'b0);
      conv(12'h922, 1'b0, 1'b0, 1'b0, 1'b0);
      read_check(12'h000, 1'b0, 1'b0);
      conv(12'h333, 1'b0, 1'b0, 1'b1, 1'b1);
      read_check(12'h111 ^ 12'hFFF, 1'b0, 1'b0);
      extra_shift <= 1'b1;
      conv(12'hC44, 1'b0, 1'b0, 1'b0, 1'b0);
      read_check(12'h922, 1'b0, 1'b0);
      `TB_CHK("tail", tail_bit, 1'b0);
      extra_shift <= 1'b0;
      $display("Test pipeline done");
      hold_load <= 1'b1;
      repeat (40) @(posedge ref_clk);
      `TB_CHK("held msb", serial_result_out, 1'b1);
      conv(12'h000, 1'b0, 1'b0, 1'b0, 1'b0);
      `TB_CHK("follow msb", serial_result_out, 1'b0);
      conv(12'h000, 1'b0, 1'b0, 1'b0, 1'b0);
      `TB_CHK("follow msb", serial_result_out, 1'b1);
      hold_load <= 1'b0;
      repeat (30) @(posedge ref_clk);
      read_check(12'hC44, 1'b0, 1'b0);
      $display("Test load priority done");
      conv(12'h501, 1'b0, 1'b0, 1'b0, 1'b0);
      conv(12'h502, 1'b0, 1'b0, 1'b0, 1'b0);
      freeze_results <= 1'b1;
      ovr_count = 0;
      for (int i = 0; i < 9; i++) conv(12'h3C0 + 12'(i), 1'b0, 1'b0, 1'b0, 1'b0);
      `TB_CHK("overruns full", ovr_count, 1);
      freeze_results <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         conv(12'h7E0 + 12'(i), 1'b0, 1'b0, 1'b0, 1'b0);
         exp_w = (i < 2) ? 12'h501 + 12'(i) : 12'h3C0 + 12'(i - 2);
         read_check(exp_w, 1'b0, 1'b0);
      end
      `TB_CHK("overruns drain", ovr_count, 2);
      $display("Test buffer done");
      finish_test();
   end
endmodule : arsp_port_test

`default_nettype wire
